/* shared/uabd_pkg.sv */
// constants shared by the autobaud measurement block and its rate generator
// assumes a 32-bit apb slave with byte addresses in an 8-bit window
package uabd_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIVL = 8'h04;
  localparam logic [7:0] ADDR_DIVH = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_RXBUF = 8'h10;
  localparam logic [7:0] ADDR_TXBUF = 8'h14;

  // ==========================================================================
  // control register fields
  localparam int CTRL_ABEN = 0;
  localparam int CTRL_WOB = 1;
  localparam int CTRL_DIV16 = 2;
  localparam int CTRL_HS = 3;
  localparam int CTRL_ASYNC = 4;
  localparam int CTRL_OVF = 7;
  localparam logic [7:0] CTRL_RST = 8'h10;

  // ==========================================================================
  // status register fields
  localparam int STAT_RXDONE = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_TXREJ = 2;

  // ==========================================================================
  // reset values of the data registers
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [7:0] TXBUF_RST = 8'h00;
  localparam logic [31:0] RXBUF_VALUE = 32'h0000_0000;

  // ==========================================================================
  // timing: divider clock period = (divisor + 1) << shift oscillator cycles
  localparam logic [4:0] SHIFT_BOTH = 5'h02;
  localparam logic [4:0] SHIFT_ONE = 5'h04;
  localparam logic [4:0] SHIFT_NONE = 5'h06;
  // measurement clocks at 1/8 of the configured rate: 512, 128, 32
  localparam logic [4:0] SHIFT_MEAS = 5'h03;
  localparam logic [4:0] SHIFT_MEAS_NONE = 5'h09;
  localparam logic [4:0] SHIFT_MEAS_ONE = 5'h07;
  localparam logic [4:0] SHIFT_MEAS_BOTH = 5'h05;
  // rising edges counted after the first one before the byte is over
  localparam logic [2:0] RISES_AFTER_FIRST = 3'h4;

  // ==========================================================================
  // measurement sequencer
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_BREAK = 5'b00010,
    ST_START = 5'b00100,
    ST_FIRST = 5'b01000,
    ST_COUNT = 5'b10000
  } uabd_state_e;

endpackage

/* rtl/uabd_rate_gen.sv */
// divider clock generator shared by normal baud timing and measurement
// assumes clk_sys_i is the oscillator clock and ce_i gates all state
`timescale 1ns/1ps
`default_nettype none

module uabd_rate_gen import uabd_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // configuration
  input wire logic measure_i,
  input wire logic restart_i,
  input wire logic div16_i,
  input wire logic hs_i,
  input wire logic [15:0] divisor_i,
  // tick, one cycle per divider period
  output logic tick_o
);

  logic [21:0] cnt;
  logic [21:0] period_m1;
  logic [4:0] shift;
  logic [21:0] div_plus1;

  // ==========================================================================
  // period selection
  assign div_plus1 = {6'h00, divisor_i} + 22'h000001;

  always_comb begin
    if (measure_i) begin
      if (div16_i && hs_i) begin
        shift = SHIFT_MEAS_BOTH;
      end else if (div16_i || hs_i) begin
        shift = SHIFT_MEAS_ONE;
      end else begin
        shift = SHIFT_MEAS_NONE;
      end
    end else if (div16_i && hs_i) begin
      shift = SHIFT_BOTH;
    end else if (div16_i || hs_i) begin
      shift = SHIFT_ONE;
    end else begin
      shift = SHIFT_NONE;
    end
  end

  // wraps to all ones for divisor ffff at shift 6, which is the right period
  assign period_m1 = measure_i ? ((22'h000001 << shift) - 22'h000001)
                               : ((div_plus1 << shift) - 22'h000001);

  // ==========================================================================
  // counter; >= so a shorter period after reconfiguration ends at once
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt <= 22'h000000;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (restart_i) begin
        cnt <= 22'h000000;
        tick_o <= 1'b0;
      end else if (cnt >= period_m1) begin
        cnt <= 22'h000000;
        tick_o <= 1'b1;
      end else begin
        cnt <= cnt + 22'h000001;
        tick_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/uabd_top.sv */
// automatic baud rate measurement with its apb register file
// assumes serial_in_pin_i is already synchronous to clk_sys_i
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - measure only in asynchronous mode, with wake-on-break set or clear
// - a start bit on the serial input begins measurement while armed
// - arming clears the divisor counter, then waits for a start bit
// - low and high bit times are both counted, averaging asymmetry
// - counting starts at the first rising edge after the start bit
// - at the fifth rising edge the count stays in the divisor bytes
// - the fifth rising edge clears the autobaud enable bit
// - counter wrap ffff to 0 sets the overflow flag; software may write it
// - after a wrap measurement continues and enable stays set
// - the counter runs at one eighth of the configured divider clock
// - counter clock is osc/512, osc/128 or osc/32 by the two selects
// - in 8-bit modes a zero high byte shows no carry occurred
// - the receive state machine is held idle during measurement
// - fifth rising edge sets receive done; reading the buffer clears it
// - with wake-on-break also set, the byte after the break is measured
// - transmit buffer writes are refused while autobaud is enabled
module uabd_top import uabd_pkg::*; (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial line
  input wire logic serial_in_pin_i,
  // towards the receive and transmit datapaths
  output logic baud_tick_o,
  output logic rx_hold_idle_o,
  output logic tx_load_o,
  output logic [7:0] tx_data_o
);

  // ==========================================================================
  // state
  logic autobaud_enable;
  logic wake_on_break_enable;
  logic divider_16bit_select;
  logic high_speed_select;
  logic async_mode;
  logic autobaud_overflow_flag;
  logic [7:0] divisor_low_byte;
  logic [7:0] divisor_high_byte;
  logic receive_done_flag;
  logic tx_reject_flag;
  logic serial_prev;
  logic [2:0] rise_cnt;
  uabd_state_e state;
  uabd_state_e next_state;

  // ==========================================================================
  // apb decode
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic hit_ctrl;
  logic hit_divl;
  logic hit_divh;
  logic hit_stat;
  logic hit_rxbuf;
  logic hit_txbuf;
  logic hit_any;
  logic tx_refused;
  logic [31:0] rd_mux;

  // the access edge is the one where the master sees pready high
  assign access = psel_i && penable_i && pready_o;
  assign wr_acc = access && pwrite_i;
  assign rd_acc = access && !pwrite_i;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_divl = 1'b0;
    hit_divh = 1'b0;
    hit_stat = 1'b0;
    hit_rxbuf = 1'b0;
    hit_txbuf = 1'b0;
    if (paddr_i == ADDR_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr_i == ADDR_DIVL) begin
      hit_divl = 1'b1;
    end else if (paddr_i == ADDR_DIVH) begin
      hit_divh = 1'b1;
    end else if (paddr_i == ADDR_STAT) begin
      hit_stat = 1'b1;
    end else if (paddr_i == ADDR_RXBUF) begin
      hit_rxbuf = 1'b1;
    end else if (paddr_i == ADDR_TXBUF) begin
      hit_txbuf = 1'b1;
    end
  end

  assign hit_any = hit_ctrl || hit_divl || hit_divh || hit_stat ||
                   hit_rxbuf || hit_txbuf;
  // the transmitter shares the reversed divider clock, so it cannot run
  assign tx_refused = hit_txbuf && pwrite_i && autobaud_enable;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[CTRL_ABEN] = autobaud_enable;
      rd_mux[CTRL_WOB] = wake_on_break_enable;
      rd_mux[CTRL_DIV16] = divider_16bit_select;
      rd_mux[CTRL_HS] = high_speed_select;
      rd_mux[CTRL_ASYNC] = async_mode;
      rd_mux[CTRL_OVF] = autobaud_overflow_flag;
    end else if (hit_divl) begin
      rd_mux[7:0] = divisor_low_byte;
    end else if (hit_divh) begin
      rd_mux[7:0] = divisor_high_byte;
    end else if (hit_stat) begin
      rd_mux[STAT_RXDONE] = receive_done_flag;
      rd_mux[STAT_BUSY] = (state != ST_IDLE);
      rd_mux[STAT_TXREJ] = tx_reject_flag;
    end else if (hit_rxbuf) begin
      rd_mux = RXBUF_VALUE;
    end
  end

  // ==========================================================================
  // serial edges and software events
  logic serial_rise;
  logic serial_fall;
  logic arm_req;
  logic disarm_req;
  logic last_rise;
  logic meas_tick;
  logic count_tick;
  logic wrap;
  logic done;
  logic break_over;
  logic abort;
  logic [15:0] divisor;
  logic [15:0] next_divisor;

  assign serial_rise = serial_in_pin_i && !serial_prev;
  assign serial_fall = !serial_in_pin_i && serial_prev;
  assign divisor = {divisor_high_byte, divisor_low_byte};

  // a write with the enable set while idle arms; mode must be asynchronous
  assign arm_req = wr_acc && hit_ctrl && pwdata_i[CTRL_ABEN] &&
                   !autobaud_enable && pwdata_i[CTRL_ASYNC];
  assign disarm_req = wr_acc && hit_ctrl && !pwdata_i[CTRL_ABEN];
  assign abort = disarm_req || !async_mode;

  assign last_rise = (rise_cnt == RISES_AFTER_FIRST - 3'h1);
  assign count_tick = meas_tick && (state == ST_COUNT);
  // a wrap is only trapped; the sequence goes on with the enable set
  assign wrap = count_tick && (divisor == 16'hFFFF);
  // the fifth rising edge ends the byte, normally in the stop bit
  assign done = (state == ST_COUNT) && serial_rise && last_rise;
  assign break_over = (state == ST_BREAK) && serial_rise;

  // ==========================================================================
  // measurement sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (arm_req) begin
          // with wake-on-break set the break is skipped first
          if (pwdata_i[CTRL_WOB]) begin
            next_state = ST_BREAK;
          end else begin
            next_state = ST_START;
          end
        end
      end
      ST_BREAK: begin
        if (abort) begin
          next_state = ST_IDLE;
        end else if (serial_rise) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (abort) begin
          next_state = ST_IDLE;
        end else if (wake_on_break_enable) begin
          next_state = ST_BREAK;
        end else if (serial_fall) begin
          next_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (abort) begin
          next_state = ST_IDLE;
        end else if (serial_rise) begin
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (abort || done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // divisor: a live counter while measuring, plain storage otherwise
  always_comb begin
    next_divisor = divisor;
    if (arm_req) begin
      next_divisor = DIV_RST;
    end else if (count_tick) begin
      // low and high bits are timed alike across the byte
      // high byte collects carries, so it stays 00h in 8-bit use
      next_divisor = divisor + 16'h0001;
    end else if (wr_acc && hit_divl && !autobaud_enable) begin
      next_divisor = {divisor_high_byte, pwdata_i[7:0]};
    end else if (wr_acc && hit_divh && !autobaud_enable) begin
      next_divisor = {pwdata_i[7:0], divisor_low_byte};
    end
  end

  uabd_rate_gen u_rate_gen (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .measure_i(autobaud_enable),
    .restart_i(state == ST_FIRST && serial_rise),
    .div16_i(divider_16bit_select),
    .hs_i(high_speed_select),
    .divisor_i(divisor),
    .tick_o(meas_tick)
  );

  // ==========================================================================
  // sequencer registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      serial_prev <= 1'b1;
      rise_cnt <= 3'h0;
      divisor_low_byte <= DIV_RST[7:0];
      divisor_high_byte <= DIV_RST[15:8];
    end else if (ce_i) begin
      state <= next_state;
      serial_prev <= serial_in_pin_i;
      divisor_low_byte <= next_divisor[7:0];
      divisor_high_byte <= next_divisor[15:8];
      if (state != ST_COUNT) begin
        rise_cnt <= 3'h0;
      end else if (serial_rise) begin
        rise_cnt <= rise_cnt + 3'h1;
      end
    end
  end

  // ==========================================================================
  // control bits
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      autobaud_enable <= CTRL_RST[CTRL_ABEN];
      wake_on_break_enable <= CTRL_RST[CTRL_WOB];
      divider_16bit_select <= CTRL_RST[CTRL_DIV16];
      high_speed_select <= CTRL_RST[CTRL_HS];
      async_mode <= CTRL_RST[CTRL_ASYNC];
    end else if (ce_i) begin
      if (wr_acc && hit_ctrl) begin
        autobaud_enable <= arm_req || (autobaud_enable &&
                           pwdata_i[CTRL_ABEN] && !done);
        wake_on_break_enable <= pwdata_i[CTRL_WOB] && !break_over;
        divider_16bit_select <= pwdata_i[CTRL_DIV16];
        high_speed_select <= pwdata_i[CTRL_HS];
        async_mode <= pwdata_i[CTRL_ASYNC];
      end else begin
        if (done || !async_mode) begin
          autobaud_enable <= 1'b0;
        end
        if (break_over) begin
          wake_on_break_enable <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // flags: a hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      autobaud_overflow_flag <= CTRL_RST[CTRL_OVF];
      receive_done_flag <= 1'b0;
      tx_reject_flag <= 1'b0;
    end else if (ce_i) begin
      if (wrap) begin
        autobaud_overflow_flag <= 1'b1;
      end else if (wr_acc && hit_ctrl) begin
        autobaud_overflow_flag <= pwdata_i[CTRL_OVF];
      end
      if (done) begin
        receive_done_flag <= 1'b1;
      end else if (rd_acc && hit_rxbuf) begin
        receive_done_flag <= 1'b0;
      end
      if (wr_acc && tx_refused) begin
        tx_reject_flag <= 1'b1;
      end else if (wr_acc && hit_stat && pwdata_i[STAT_TXREJ]) begin
        tx_reject_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // apb answer: one wait state, so every access takes exactly three cycles
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (psel_i && penable_i && !pready_o) begin
        pready_o <= 1'b1;
        pslverr_o <= !hit_any || tx_refused;
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end else begin
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // datapath side outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      baud_tick_o <= 1'b0;
      rx_hold_idle_o <= 1'b0;
      tx_load_o <= 1'b0;
      tx_data_o <= TXBUF_RST;
    end else if (ce_i) begin
      // the divider is borrowed as a counter, so no baud ticks leave
      baud_tick_o <= meas_tick && !autobaud_enable;
      rx_hold_idle_o <= (next_state != ST_IDLE);
      tx_load_o <= wr_acc && hit_txbuf && !autobaud_enable;
      if (wr_acc && hit_txbuf && !autobaud_enable) begin
        tx_data_o <= pwdata_i[7:0];
      end
    end
  end

endmodule

`default_nettype wire

/* testbench/uabd_checker.sv */
// assertion checker for the autobaud block, bound to uabd_top
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

// ====================
// port checker
module uabd_checker import uabd_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // serial line and datapath side
  input wire logic serial_in_pin_i,
  input wire logic baud_tick_o,
  input wire logic rx_hold_idle_o,
  input wire logic tx_load_o,
  input wire logic [7:0] tx_data_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic acc = ce_i && psel_i && penable_i && pready_o;
  wire logic arm = acc && pwrite_i && paddr_i == ADDR_CTRL
    && pwdata_i[CTRL_ABEN] && pwdata_i[CTRL_ASYNC];
  wire logic tx_wr = pwrite_i && paddr_i == ADDR_TXBUF;

  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready stood more than one cycle");
  ready_wait_a: assert property (
    ce_i && psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase not answered after one wait");
  tx_block_a: assert property (
    acc && tx_wr && rx_hold_idle_o |-> pslverr_o)
    else $error("transmit write accepted while measuring");
  tx_cause_a: assert property (
    tx_load_o |-> $past(tx_wr) && tx_data_o == $past(pwdata_i[7:0]))
    else $error("transmit load without its write");
  rxbuf_zero_a: assert property (
    acc && !pwrite_i && paddr_i == ADDR_RXBUF |-> prdata_o == RXBUF_VALUE)
    else $error("receive buffer read not zero");
  hold_start_a: assert property (
    $rose(rx_hold_idle_o) |-> $past(arm) || $past(arm, 2))
    else $error("receiver held without arming");
  hold_end_a: assert property (
    $fell(rx_hold_idle_o) |-> $past(serial_in_pin_i) || $past(psel_i, 2))
    else $error("measurement ended without a rising input");
  tick_quiet_a: assert property (
    rx_hold_idle_o && $past(rx_hold_idle_o) |-> !baud_tick_o)
    else $error("rate tick while measuring");
  tick_gap_a: assert property (
    baud_tick_o |=> !baud_tick_o [*3])
    else $error("rate ticks closer than four clocks");
  done_c: cover property ($fell(rx_hold_idle_o));
  refuse_c: cover property (acc && tx_wr && pslverr_o);
  load_c: cover property (tx_load_o);
endmodule

bind uabd_top uabd_checker u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .serial_in_pin_i(serial_in_pin_i),
  .baud_tick_o(baud_tick_o), .rx_hold_idle_o(rx_hold_idle_o),
  .tx_load_o(tx_load_o), .tx_data_o(tx_data_o));
`default_nettype wire

/* testbench/uabd_far_tx.sv */
// far-end transmitter that sends the calibration character
// assumes the line idles high and bit_clks_i holds still per frame
`timescale 1ns/1ps
`default_nettype none

// ====================
// remote transmitter model
module uabd_far_tx (
  // clock
  input wire logic clk_sys_i,
  // command
  input wire logic go_i,
  input wire logic brk_i,
  input wire logic [15:0] bit_clks_i,
  // line
  output logic line_o,
  output logic busy_o
);
  localparam logic [7:0] CAL_BYTE = 8'h55;
  task automatic hold_bit(input logic v);
    line_o <= v;
    repeat (bit_clks_i) @(posedge clk_sys_i);
  endtask
  // one process owns the line and busy, so each has a single driver
  initial begin
    line_o <= 1'h1;
    busy_o <= 1'h0;
    forever begin
      @(posedge clk_sys_i);
      if (go_i) begin
        busy_o <= 1'h1;
        // a break is 13 low bit times, so it can never pass for a start
        if (brk_i) begin
          repeat (13) hold_bit(1'h0);
          hold_bit(1'h1);
        end
        hold_bit(1'h0);
        for (int i = 0; i < 8; i++) hold_bit(CAL_BYTE[i]);
        hold_bit(1'h1);
        busy_o <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/uabd_top_bench.sv */
// self-checking bench for the autobaud block over apb
// assumes the far-end model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none

// ====================
// bench top
module uabd_top_bench import uabd_pkg::*;;
  localparam int MEAS_N = 20;
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, serial_in_pin_i, baud_tick_o;
  logic rx_hold_idle_o, tx_load_o, far_busy;
  logic [7:0] tx_data_o;
  logic go = 1'h0;
  logic wob = 1'h0;
  logic [15:0] bit_clks = 16'h0010;
  int n_mismatch = 0;
  int check_count = 0;
  int tx_cnt = 0;

  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (tx_load_o === 1'h1) tx_cnt++;

  uabd_top DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .serial_in_pin_i(serial_in_pin_i),
    .baud_tick_o(baud_tick_o), .rx_hold_idle_o(rx_hold_idle_o),
    .tx_load_o(tx_load_o), .tx_data_o(tx_data_o));
  uabd_far_tx u_far (.clk_sys_i(clk_sys_i), .go_i(go), .brk_i(wob),
    .bit_clks_i(bit_clks), .line_o(serial_in_pin_i), .busy_o(far_busy));

  // ====================
  // reporting and bus tasks
  task automatic end_sim;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic give_up;
    n_mismatch++;
    $display("MISMATCH %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_near(input logic [31:0] got, input int lo, input int hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'h1) begin
      n_mismatch++;
      $display("MISMATCH %0t count %h outside window", $time, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    if (pready_o !== 1'h1) give_up();
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    // idle cycle so the next setup never lands in this time step
    @(posedge clk_sys_i);
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] wd,
      input logic e);
    logic [31:0] d;
    logic err;
    apb(1'h1, a, wd, d, err);
    cmp({31'h0, err}, {31'h0, e});
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp,
      input logic e);
    logic [31:0] d;
    logic err;
    apb(1'h0, a, 32'h0000_0000, d, err);
    cmp(d, exp);
    cmp({31'h0, err}, {31'h0, e});
  endtask
  function automatic logic [31:0] ctl(input logic en, input logic wk,
      input logic d16, input logic hs, input logic ov);
    logic [31:0] c;
    c = 32'h0000_0000;
    c[CTRL_ABEN] = en;
    c[CTRL_WOB] = wk;
    c[CTRL_DIV16] = d16;
    c[CTRL_HS] = hs;
    c[CTRL_ASYNC] = 1'h1;
    c[CTRL_OVF] = ov;
    return c;
  endfunction

  // ====================
  // scenarios
  task automatic t_reset;
    chk(ADDR_CTRL, {24'h0, CTRL_RST}, 1'h0);
    chk(ADDR_DIVL, {24'h0, DIV_RST[7:0]}, 1'h0);
    chk(ADDR_DIVH, {24'h0, DIV_RST[15:8]}, 1'h0);
    chk(ADDR_STAT, 32'h0000_0000, 1'h0);
    chk(8'h18, 32'h0000_0000, 1'h1);
  endtask
  task automatic t_flags;
    put(ADDR_CTRL, ctl(1'h0, 1'h0, 1'h0, 1'h0, 1'h1), 1'h0);
    chk(ADDR_CTRL, ctl(1'h0, 1'h0, 1'h0, 1'h0, 1'h1), 1'h0);
    // enable with async mode cleared must not arm
    put(ADDR_CTRL, 32'h0000_0001 << CTRL_ABEN, 1'h0);
    chk(ADDR_CTRL, 32'h0000_0000, 1'h0);
    cmp({31'h0, rx_hold_idle_o}, 32'h0000_0000);
  endtask
  task automatic t_tx;
    put(ADDR_TXBUF, 32'h0000_00A5, 1'h0);
    chk(ADDR_STAT, 32'h0000_0000, 1'h0);
    cmp(32'(tx_cnt), 32'h0000_0001);
    cmp({24'h0, tx_data_o}, 32'h0000_00A5);
  endtask
  task automatic t_tick;
    int n;
    logic [4:0] sh;
    put(ADDR_DIVL, 32'h0000_0003, 1'h0);
    put(ADDR_DIVH, 32'h0000_0000, 1'h0);
    for (int m = 0; m < 4; m++) begin
      put(ADDR_CTRL, ctl(1'h0, 1'h0, m[1], m[0], 1'h0), 1'h0);
      sh = (m == 3) ? SHIFT_BOTH : (m == 0) ? SHIFT_NONE : SHIFT_ONE;
      // first pass only aligns to a tick, second one times a period
      for (int k = 0; k < 2; k++) begin
        n = 0;
        do begin
          @(posedge clk_sys_i);
          n++;
        end while (baud_tick_o !== 1'h1 && n < 600);
        if (baud_tick_o !== 1'h1) give_up();
      end
      cmp(32'(n), 32'h0000_0004 << sh);
    end
  endtask
  task automatic t_measure(input logic [1:0] m, input logic brk);
    logic [31:0] d;
    logic e;
    int n;
    int p;
    int t0;
    p = (m == 2'h3) ? 32 : (m == 2'h0) ? 512 : 128;
    bit_clks <= 16'(p * MEAS_N / 8);
    wob <= brk;
    t0 = tx_cnt;
    put(ADDR_CTRL, ctl(1'h1, brk, m[1], m[0], 1'h0), 1'h0);
    chk(ADDR_DIVL, 32'h0000_0000, 1'h0);
    chk(ADDR_DIVH, 32'h0000_0000, 1'h0);
    put(ADDR_TXBUF, 32'h0000_003C, 1'h1);
    chk(ADDR_STAT, 32'h0000_0006, 1'h0);
    cmp(32'(tx_cnt - t0), 32'h0000_0000);
    put(ADDR_STAT, 32'h0000_0004, 1'h0);
    go <= 1'h1;
    @(posedge clk_sys_i);
    go <= 1'h0;
    n = 0;
    while (rx_hold_idle_o !== 1'h0 && n < 40000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (rx_hold_idle_o !== 1'h0) give_up();
    chk(ADDR_CTRL, ctl(1'h0, 1'h0, m[1], m[0], 1'h0), 1'h0);
    chk(ADDR_STAT, 32'h0000_0001, 1'h0);
    apb(1'h0, ADDR_DIVL, 32'h0000_0000, d, e);
    cmp_near(d, MEAS_N - 1, MEAS_N + 1);
    chk(ADDR_DIVH, 32'h0000_0000, 1'h0);
    chk(ADDR_RXBUF, RXBUF_VALUE, 1'h0);
    chk(ADDR_STAT, 32'h0000_0000, 1'h0);
    n = 0;
    while (far_busy !== 1'h0 && n < 5000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (far_busy !== 1'h0) give_up();
  endtask
  // called right after a tick, so the frozen tick output is low
  task automatic t_ce;
    int n;
    n = 0;
    ce_i <= 1'h0;
    repeat (300) begin
      @(posedge clk_sys_i);
      if (baud_tick_o !== 1'h0) n++;
    end
    ce_i <= 1'h1;
    cmp(32'(n), 32'h0000_0000);
  endtask

  // ====================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    @(posedge clk_sys_i);
    t_reset();
    t_flags();
    t_tx();
    t_tick();
    t_ce();
    for (int m = 0; m < 4; m++) t_measure(2'(m), 1'h0);
    t_measure(2'h3, 1'h1);
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    give_up();
  end
endmodule
`default_nettype wire
